//--- design/lookup_table_sequencer.v
// Functional notes
// - timed wait holds for field 2 milliseconds
// - field 2 delay used only for timed option
// - cancel ends wait, no further instructions
// - float write stores field 2 at identifier
// - float fields carried as IEEE single bits
// - integer write stores signed value at identifier
// - stability wait holds until temperature stable
// - instance select changes target channel instance
// - forever wait holds until cancelled
`timescale 1ns/10ps
`include "lut_seq_defines.vh"
module lookup_table_sequencer (
    input  wire                 clk,
    input  wire                 reset,
    input  wire                 ce,
    input  wire                 load_en,
    input  wire [`ADDR_W-1:0]   load_addr,
    input  wire [`ENT_W-1:0]    load_data,
    input  wire                 start,
    input  wire                 cancel,
    input  wire                 temp_stable,
    input  wire                 param_ready,
    output reg                  param_wr_r,
    output reg                  param_is_float_r,
    output reg  [`ID_W-1:0]     parameter_identifier_r,
    output reg  [31:0]          param_value_r,
    output reg  [31:0]          instance_r,
    output reg                  busy_r,
    output reg                  done_r,
    output reg                  eof_r,
    output reg  [31:0]          checksum_r,
    output reg  [`ADDR_W-1:0]   pc_r
);
    // one-hot state codes
    localparam [6:0] S_IDLE  = 7'h01;
    localparam [6:0] S_FETCH = 7'h02;
    localparam [6:0] S_DEC   = 7'h04;
    localparam [6:0] S_TIME  = 7'h08;
    localparam [6:0] S_EVER  = 7'h10;
    localparam [6:0] S_STAB  = 7'h20;
    localparam [6:0] S_WRITE = 7'h40;
    localparam [31:0]          MS_LAST_FULL = `CYC_PER_MS - 1;
    // cycles per millisecond fit the counter, so the cut is deliberate
    localparam [`MS_CNT_W-1:0] MS_LAST = MS_LAST_FULL[`MS_CNT_W-1:0];

    ////////////////////////////////////////////////////////////////////////////
    // input synchronisers for pin-level status from the control loop
    reg               stab_s1_r;    // first stage, read only by the second
    reg               stab_s2_r;    // settled copy of the stability status
    // fields of the entry on the read port
    wire [`ENT_W-1:0] entry;
    wire [3:0]  op = entry[`ENT_OP_HI:`ENT_OP_LO];
    wire [31:0] f1 = entry[`ENT_F1_HI:`ENT_F1_LO];
    wire [31:0] f2 = entry[`ENT_F2_HI:`ENT_F2_LO];

    // two flops: the status comes from outside this clock domain
    always @(posedge clk) begin
        if (reset) begin
            stab_s1_r <= 1'b0;
            stab_s2_r <= 1'b0;
        end else if (ce) begin
            stab_s1_r <= temp_stable;
            stab_s2_r <= stab_s1_r;
        end
    end

    // table storage; loads are refused while a table runs
    lut_table_mem lut_table_mem_inst (
        .clk       (clk),
        .ce        (ce),
        .wr_en     (load_en & ~busy_r),
        .wr_addr   (load_addr),
        .wr_data   (load_data),
        .rd_addr   (pc_r),
        .rd_data_r (entry)
    );

    ////////////////////////////////////////////////////////////////////////////
    // sequencer
    reg [6:0]            state_r;
    reg [`MS_CNT_W-1:0]  cyc_r;
    reg [30:0]           ms_r;
    wire                 ms_tick;
    wire                 time_up;
    wire                 timer_load;

    // end of one millisecond and end of the whole wait
    assign ms_tick    = (cyc_r == MS_LAST);
    assign time_up    = (ms_r == 31'h0000_0000);
    // a timed wait loads the timer as it is decoded
    assign timer_load = (state_r == S_DEC) && (op == `OP_WAIT) && (f1 == `WAIT_OPT_TIME);

    ////////////////////////////////////////////////////////////////////////////
    // millisecond timer: counts down whole milliseconds while in S_TIME
    always @(posedge clk) begin
        if (reset) begin
            cyc_r <= {`MS_CNT_W{1'b0}};
            ms_r  <= 31'h0000_0000;
        end else if (ce) begin
            if (timer_load) begin
                // only the low 31 bits: the delay is never negative
                ms_r  <= f2[30:0];
                cyc_r <= {`MS_CNT_W{1'b0}};
            end else if ((state_r == S_TIME) && !time_up) begin
                // run only while the sequencer waits on the timer
                if (ms_tick) begin
                    cyc_r <= {`MS_CNT_W{1'b0}};
                    ms_r  <= ms_r - 1'b1;
                end else begin
                    cyc_r <= cyc_r + 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // one instruction at a time, cancel wins over every state but S_IDLE
    always @(posedge clk) begin
        if (reset) begin
            // all outputs low; the table memory keeps its contents
            state_r                <= S_IDLE;
            pc_r                   <= {`ADDR_W{1'b0}};
            param_wr_r             <= 1'b0;
            param_is_float_r       <= 1'b0;
            parameter_identifier_r <= {`ID_W{1'b0}};
            param_value_r          <= 32'h0000_0000;
            instance_r             <= 32'h0000_0000;
            busy_r                 <= 1'b0;
            done_r                 <= 1'b0;
            eof_r                  <= 1'b0;
            checksum_r             <= 32'h0000_0000;
        end else if (ce) begin
            // done is a one-cycle pulse
            done_r <= 1'b0;
            if (cancel && busy_r) begin
                // abort anything in progress, table stops here
                state_r    <= S_IDLE;
                busy_r     <= 1'b0;
                param_wr_r <= 1'b0;
                done_r     <= 1'b1;
            end else begin
                case (state_r)
                    // wait for a start, always from entry 0
                    S_IDLE: begin
                        if (start) begin
                            pc_r    <= {`ADDR_W{1'b0}};
                            busy_r  <= 1'b1;
                            eof_r   <= 1'b0;
                            state_r <= S_FETCH;
                        end
                    end
                    S_FETCH: begin
                        // read data of pc_r appears next cycle
                        state_r <= S_DEC;
                    end
                    // decode the entry and step past it
                    S_DEC: begin
                        pc_r <= pc_r + 1'b1;
                        state_r <= S_FETCH;
                        case (op)
                            // a wait: timed, or unbounded for any other option
                            `OP_WAIT: begin
                                if (f1 == `WAIT_OPT_TIME) begin
                                    // the timer loads field 2 at this same edge
                                    state_r <= S_TIME;
                                end else begin
                                    state_r <= S_EVER;
                                end
                            end
                            `OP_SET_FLOAT, `OP_SET_INT: begin
                                // value passed as raw bits: IEEE single or int32
                                parameter_identifier_r <= f1[`ID_W-1:0];
                                param_value_r    <= f2;
                                param_is_float_r <= (op == `OP_SET_FLOAT);
                                param_wr_r       <= 1'b1;
                                state_r          <= S_WRITE;
                            end
                            // hold for stability, or switch the target instance
                            `OP_WAIT_STABLE: state_r <= S_STAB;
                            `OP_SELECT_INSTANCE: instance_r <= f1;
                            // end mark: report the checksum and go idle
                            `OP_EOF: begin
                                checksum_r <= f2;
                                eof_r      <= 1'b1;
                                busy_r     <= 1'b0;
                                done_r     <= 1'b1;
                                state_r    <= S_IDLE;
                            end
                            default: ;  // unknown entries are skipped
                        endcase
                    end
                    S_TIME: begin
                        // leave once the timer has run out, zero means no wait
                        if (time_up) begin
                            state_r <= S_FETCH;
                        end
                    end
                    // unbounded wait: only cancel or reset leaves it
                    S_EVER: state_r <= S_EVER;
                    // wait for the settled stability status
                    S_STAB: begin
                        if (stab_s2_r) begin
                            state_r <= S_FETCH;
                        end
                    end
                    S_WRITE: begin
                        // hold the write until the parameter store takes it
                        if (param_ready) begin
                            param_wr_r <= 1'b0;
                            state_r    <= S_FETCH;
                        end
                    end
                    default: state_r <= S_IDLE;
                endcase
            end
        end
    end
endmodule // lookup_table_sequencer

//--- design/lut_seq_defines.vh
`ifndef LUT_SEQ_DEFINES_VH
`define LUT_SEQ_DEFINES_VH
// instruction opcodes (4-bit field of a table entry)
`define OP_WAIT            4'h0
`define OP_SET_FLOAT       4'h1
`define OP_SET_INT         4'h2
`define OP_WAIT_STABLE     4'h3
`define OP_SELECT_INSTANCE 4'h4
`define OP_EOF             4'hF
// wait options in field 1
`define WAIT_OPT_FOREVER   32'h0000_0000
`define WAIT_OPT_TIME      32'h0000_0001
// entry layout: [67:64] opcode, [63:32] field 1, [31:0] field 2
`define ENT_W              68
`define ENT_OP_HI          67
`define ENT_OP_LO          64
`define ENT_F1_HI          63
`define ENT_F1_LO          32
`define ENT_F2_HI          31
`define ENT_F2_LO          0
`define ID_W               24
`define ADDR_W             8
`define DEPTH              256
// time base
`define CLK_HZ             40000000
`define TICK_MS            1
`define CYC_PER_MS         ((`CLK_HZ / 1000) * `TICK_MS)
`define MS_CNT_W           16
`endif

//--- design/lut_table_mem.v
`timescale 1ns/10ps
`include "lut_seq_defines.vh"
// table storage with registered read data
module lut_table_mem (
    input  wire                 clk,
    input  wire                 ce,
    input  wire                 wr_en,
    input  wire [`ADDR_W-1:0]   wr_addr,
    input  wire [`ENT_W-1:0]    wr_data,
    input  wire [`ADDR_W-1:0]   rd_addr,
    output reg  [`ENT_W-1:0]    rd_data_r
);
    reg [`ENT_W-1:0] mem [0:`DEPTH-1];

    // write port and registered read port
    always @(posedge clk) begin
        if (ce) begin
            if (wr_en) begin
                mem[wr_addr] <= wr_data;
            end
            rd_data_r <= mem[rd_addr];
        end
    end
endmodule // lut_table_mem

//--- dv/lookup_table_sequencer_properties.sv
`timescale 1ns/10ps
`include "lut_seq_defines.vh"
// watches the sequencer ports only
module lookup_table_sequencer_properties (
    input wire               clk,
    input wire               reset,
    input wire               ce,
    input wire               start,
    input wire               cancel,
    input wire               param_ready,
    input wire               param_wr_r,
    input wire [31:0]        param_value_r,
    input wire               busy_r,
    input wire               done_r,
    input wire               eof_r,
    input wire [`ADDR_W-1:0] pc_r
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    property p_hold; param_wr_r && !param_ready && !cancel && ce |=> param_wr_r && $stable(param_value_r); endproperty
    a_hold: assert property (p_hold) else $error("write dropped early");
    property p_done; done_r && ce |=> !done_r; endproperty
    a_done: assert property (p_done) else $error("done too long");
    property p_ack; param_wr_r && param_ready && ce |=> !param_wr_r; endproperty
    a_ack: assert property (p_ack) else $error("write held after accept");
    property p_eof; $rose(eof_r) |-> !busy_r && done_r; endproperty
    a_eof: assert property (p_eof) else $error("end not idle");
    property p_cancel; busy_r && cancel && ce |=> !busy_r && !param_wr_r && done_r; endproperty
    a_cancel: assert property (p_cancel) else $error("cancel late");
    property p_idle; !busy_r |-> !param_wr_r; endproperty
    a_idle: assert property (p_idle) else $error("write while idle");
    property p_pc; param_wr_r && !param_ready |=> $stable(pc_r); endproperty
    a_pc: assert property (p_pc) else $error("advanced early");
    property p_start; !busy_r && start && !cancel && ce |=> busy_r && pc_r == 8'h00; endproperty
    a_start: assert property (p_start) else $error("bad start");
    property p_keep; eof_r && !start |=> eof_r; endproperty
    a_keep: assert property (p_keep) else $error("end flag lost");
endmodule // lookup_table_sequencer_properties
bind lookup_table_sequencer lookup_table_sequencer_properties lookup_table_sequencer_properties_inst (
    .clk(clk), .reset(reset), .ce(ce), .start(start), .cancel(cancel), .param_ready(param_ready),
    .param_wr_r(param_wr_r), .param_value_r(param_value_r), .busy_r(busy_r), .done_r(done_r),
    .eof_r(eof_r), .pc_r(pc_r));

//--- dv/lookup_table_sequencer_tb.sv
`timescale 1ns/10ps
`include "lut_seq_defines.vh"
module lookup_table_sequencer_tb;
    reg               clk, reset, load_en, start, cancel, temp_stable;
    reg [7:0]         load_addr;
    reg [`ENT_W-1:0]  load_data;
    wire              param_ready, param_wr_r, param_is_float_r, busy_r, done_r, eof_r;
    wire [`ID_W-1:0]  parameter_identifier_r;
    wire [31:0]       param_value_r, instance_r, checksum_r, acc_cnt, n;
    wire [7:0]        pc_r;
    integer           errors, check_count, i, base;
    lookup_table_sequencer lookup_table_sequencer_inst (.clk(clk), .reset(reset), .ce(1'b1),
        .load_en(load_en), .load_addr(load_addr), .load_data(load_data), .start(start),
        .cancel(cancel), .temp_stable(temp_stable), .param_ready(param_ready),
        .param_wr_r(param_wr_r), .param_is_float_r(param_is_float_r),
        .parameter_identifier_r(parameter_identifier_r), .param_value_r(param_value_r),
        .instance_r(instance_r), .busy_r(busy_r), .done_r(done_r), .eof_r(eof_r),
        .checksum_r(checksum_r), .pc_r(pc_r));
    param_store_model param_store_model_inst (.clk(clk), .param_wr_r(param_wr_r),
        .param_ready(param_ready), .acc_cnt(acc_cnt));
    assign n = base;
    task chk(input [47:0] name, input [31:0] exp, input [31:0] got);
        begin
            check_count = check_count + 1;
            if (got !== exp) begin
                errors = errors + 1;
                $display("ERROR %0s exp %h got %h", name, exp, got);
            end
        end
    endtask
    task put(input [7:0] a, input [3:0] op, input [31:0] f1, input [31:0] f2);
        begin
            @(posedge clk) {load_en, load_addr, load_data} <= {1'b1, a, op, f1, f2};
            @(posedge clk) load_en <= 1'b0;
        end
    endtask
    task pulse_start;
        begin
            base = acc_cnt;
            @(posedge clk) start <= 1'b1;
            @(posedge clk) start <= 1'b0;
        end
    endtask
    task wr(input fl, input [23:0] id, input [31:0] v);
        begin
            // look between edges, where the request and the answer are settled
            i = 0;
            @(negedge clk);
            while (i < 200 && !(param_wr_r === 1'b1 && param_ready === 1'b1)) begin
                i = i + 1;
                @(negedge clk);
            end
            chk("ack", 32'h1, {31'h0, param_wr_r & param_ready});
            chk("float", {31'h0, fl}, {31'h0, param_is_float_r});
            chk("id", {8'h00, id}, {8'h00, parameter_identifier_r});
            chk("value", v, param_value_r);
            // the store takes the write at the next rising edge
            @(posedge clk);
        end
    endtask
    task wait_done(input [31:0] pc_exp);
        begin
            i = 0;
            @(negedge clk);
            while (i < 100 && done_r !== 1'b1) begin
                i = i + 1;
                @(negedge clk);
            end
            chk("done", 32'h1, {31'h0, done_r});
            chk("busy", 32'h0, {31'h0, busy_r});
            chk("pc", pc_exp, {24'h0, pc_r});
            @(negedge clk);
            chk("pulse", 32'h0, {31'h0, done_r});
        end
    endtask
    task t_params;
        begin
            put(8'h0, `OP_SET_FLOAT, 32'h00FF_FFFF, 32'h3F80_0000);
            put(8'h1, `OP_SET_INT, 32'h0000_0001, 32'h8000_0000);
            put(8'h2, `OP_SELECT_INSTANCE, 32'h0000_0002, 32'h0);
            put(8'h3, `OP_SET_INT, 32'h0, 32'hFFFF_FFFF);
            put(8'h4, `OP_EOF, 32'h0, 32'h1234_5678);
            pulse_start;
            wr(1'b1, 24'hFF_FFFF, 32'h3F80_0000);
            wr(1'b0, 24'h00_0001, 32'h8000_0000);
            wr(1'b0, 24'h00_0000, 32'hFFFF_FFFF);
            chk("inst", 32'h2, instance_r);
            wait_done(32'h5);
            chk("eof", 32'h1, {31'h0, eof_r & ~busy_r});
            chk("sum", 32'h1234_5678, checksum_r);
            $display("test params done");
        end
    endtask
    task t_timed;
        begin
            put(8'h0, `OP_WAIT, `WAIT_OPT_TIME, 32'h1);
            put(8'h1, `OP_SET_FLOAT, 32'h7, 32'h4049_0FDB);
            put(8'h2, `OP_WAIT_STABLE, 32'h0, 32'h0);
            put(8'h3, `OP_SET_INT, 32'h8, 32'h9);
            put(8'h4, `OP_EOF, 32'h0, 32'h5A5A_0F0F);
            pulse_start;
            // a write before 1 ms has run out would show in the count
            repeat (39990) @(posedge clk);
            chk("early", n, acc_cnt);
            wr(1'b1, 24'h7, 32'h4049_0FDB);
            repeat (300) @(posedge clk);
            chk("stab", n + 32'h1, acc_cnt);
            temp_stable <= 1'b1;
            wr(1'b0, 24'h8, 32'h9);
            wait_done(32'h5);
            chk("sum", 32'h5A5A_0F0F, checksum_r);
            @(posedge clk) temp_stable <= 1'b0;
            $display("test timed done");
        end
    endtask
    task t_forever;
        begin
            put(8'h0, `OP_WAIT, `WAIT_OPT_FOREVER, 32'h1);
            put(8'h1, `OP_SET_INT, 32'h5, 32'h5);
            put(8'h2, `OP_EOF, 32'h0, 32'h0000_0055);
            pulse_start;
            // field 2 of 1 ms must not be taken as a delay here
            repeat (41000) @(posedge clk);
            chk("hold", n, acc_cnt);
            chk("busy", 32'h1, {31'h0, busy_r});
            @(posedge clk) cancel <= 1'b1;
            @(posedge clk) cancel <= 1'b0;
            wait_done(32'h1);
            repeat (20) @(posedge clk);
            chk("stop", n, acc_cnt);
            chk("pc", 32'h1, {24'h0, pc_r});
            chk("eof", 32'h0, {31'h0, eof_r});
            $display("test forever done");
        end
    endtask
    task test_done;
        begin
            $display("checks %0d errors %0d", check_count, errors);
            if (errors == 0 && check_count > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask
    // clock and main sequence
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        {reset, load_en, start, cancel, temp_stable, load_addr, load_data} = {1'b1, 80'h0};
        {errors, check_count, base} = 96'h0;
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        t_params;
        t_timed;
        t_forever;
        test_done;
    end
    // watchdog on the whole run
    initial begin
        #2250000 errors = errors + 1;
        test_done;
    end
endmodule // lookup_table_sequencer_tb

//--- dv/param_store_model.sv
`timescale 1ns/10ps
// parameter store: accepts writes after short and long stalls in turn
module param_store_model (
    input  wire        clk,
    input  wire        param_wr_r,
    output reg         param_ready,
    output reg  [31:0] acc_cnt
);
    reg [1:0] wait_r;
    reg       slow_r;
    initial begin
        param_ready = 1'b0;
        acc_cnt = 32'h0;
        wait_r = 2'h0;
        slow_r = 1'b0;
    end
    // count accepted writes, answer after 2 or 4 cycles
    always @(posedge clk) begin
        if (param_wr_r && param_ready)
            acc_cnt <= acc_cnt + 32'h1;
        param_ready <= param_wr_r && !param_ready && wait_r == {slow_r, 1'b1};
        wait_r <= (param_wr_r && !param_ready) ? wait_r + 2'h1 : 2'h0;
        if (param_wr_r && param_ready)
            slow_r <= ~slow_r;
    end
endmodule // param_store_model
